// file: design/alert_ctrl.sv
// drives the open-drain alert line and the notification pulses
`timescale 1ns/1ps
module alert_ctrl (
   input  wire logic ref_clk,
   input  wire logic rst,
   input  wire logic fault_set,
   input  wire logic warn_set,
   input  wire logic clear,
   output logic      alert_n_o,
   output logic      alert_n_oe,
   output logic      fault_notify,
   output logic      warn_notify
);
   typedef struct packed {
      logic alert;
      logic fn;
      logic wn;
   } alert_state_t;

   alert_state_t st_r;
   alert_state_t st_nxt;

   // a new crossing in the clearing cycle keeps the line asserted
   always_comb begin
      st_nxt       = st_r;
      st_nxt.alert = (st_r.alert & ~clear) | fault_set | warn_set;
      st_nxt.fn    = fault_set;
      st_nxt.wn    = warn_set;
   end

   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         st_r <= '0;
      end else begin
         st_r <= st_nxt;
      end
   end

   // line is pulled low only while asserted
   assign alert_n_o    = 1'b0;
   assign alert_n_oe   = st_r.alert;
   assign fault_notify = st_r.fn;
   assign warn_notify  = st_r.wn;
endmodule : alert_ctrl

// file: design/fault_pkg.sv
// shared constants, command codes and bit positions of the output fault supervisor
package fault_pkg;
   typedef logic [15:0] word_t;
   typedef logic [7:0]  byte_t;

   ////////////////////////////////////////////////////////////////////////////
   // command codes seen on the management link
   localparam byte_t CMD_CLEAR      = 8'h03;
   localparam byte_t CMD_VOLT_FMT   = 8'h20;
   localparam byte_t CMD_OV_FLIM    = 8'h40;
   localparam byte_t CMD_OV_FACT    = 8'h41;
   localparam byte_t CMD_OV_WLIM    = 8'h42;
   localparam byte_t CMD_UV_WLIM    = 8'h43;
   localparam byte_t CMD_UV_FLIM    = 8'h44;
   localparam byte_t CMD_UV_FACT    = 8'h45;
   localparam byte_t CMD_OC_FLIM    = 8'h46;
   localparam byte_t CMD_OC_FACT    = 8'h47;
   localparam byte_t CMD_LV_FLIM    = 8'h48;
   localparam byte_t CMD_LV_FACT    = 8'h49;
   localparam byte_t CMD_ST_BYTE    = 8'h78;
   localparam byte_t CMD_ST_WORD    = 8'h79;
   localparam byte_t CMD_ST_VOLT    = 8'h7a;
   localparam byte_t CMD_ST_CURR    = 8'h7b;

   ////////////////////////////////////////////////////////////////////////////
   // status bit positions
   localparam int SB_VOLT_HIGH  = 5;
   localparam int SB_CURR_HIGH  = 4;
   localparam int SB_OTHER      = 0;
   localparam int SW_VOLT       = 7;
   localparam int SW_CURR       = 6;
   localparam int VS_HIGH_FAULT = 7;
   localparam int VS_HIGH_WARN  = 6;
   localparam int VS_LOW_WARN   = 5;
   localparam int VS_LOW_FAULT  = 4;
   localparam int CS_HIGH_FAULT = 7;
   localparam int CS_LOW_VOLT   = 6;

   ////////////////////////////////////////////////////////////////////////////
   // number format and action fields
   localparam int           FMT_HI     = 7;
   localparam int           FMT_LO     = 5;
   localparam logic [2:0]   FMT_SIGNED = 3'h3;
   localparam int           ACT_HI     = 7;
   localparam int           ACT_LO     = 6;
   localparam logic [1:0]   ACT_CC     = 2'h0;
   localparam logic [1:0]   ACT_LATCH  = 2'h2;
   localparam logic         CURR_SIGNED = 1'b0;

   ////////////////////////////////////////////////////////////////////////////
   // reset values
   localparam word_t LIMIT_ZERO   = 16'h0000;
   localparam word_t LIMIT_TOP    = 16'hffff;
   localparam byte_t BYTE_ZERO    = 8'h00;

   // greater-than in the format selected for the operands
   function automatic logic fmt_gt(word_t a, word_t b, logic sgn);
      if (sgn) begin
         return $signed(a) > $signed(b);
      end
      return a > b;
   endfunction : fmt_gt
endpackage : fault_pkg

// file: design/limit_compare.sv
// compares measured output voltage and current against the programmed limits
`timescale 1ns/1ps
module limit_compare (
   limit_if.cmp lim
);
   import fault_pkg::*;

   // voltage limits follow the selected number format
   assign lim.ov_f     = fmt_gt(lim.meas_volt, lim.ov_fl, lim.signed_fmt);
   assign lim.ov_w     = fmt_gt(lim.meas_volt, lim.ov_wl, lim.signed_fmt);
   assign lim.uv_w     = fmt_gt(lim.uv_wl, lim.meas_volt, lim.signed_fmt);
   assign lim.uv_f     = fmt_gt(lim.uv_fl, lim.meas_volt, lim.signed_fmt);
   assign lim.lv_below = fmt_gt(lim.lv_fl, lim.meas_volt, lim.signed_fmt);
   assign lim.oc_f     = fmt_gt(lim.meas_curr, lim.oc_fl, CURR_SIGNED);
endmodule : limit_compare

// file: design/limit_if.sv
// limits, measurements and crossing results between supervisor and comparator
`timescale 1ns/1ps
interface limit_if;
   import fault_pkg::*;
   logic  signed_fmt;
   word_t meas_volt;
   word_t meas_curr;
   word_t ov_fl;
   word_t ov_wl;
   word_t uv_wl;
   word_t uv_fl;
   word_t oc_fl;
   word_t lv_fl;
   logic  ov_f;
   logic  ov_w;
   logic  uv_w;
   logic  uv_f;
   logic  oc_f;
   logic  lv_below;
   modport cfg (output signed_fmt, meas_volt, meas_curr, ov_fl, ov_wl, uv_wl, uv_fl, oc_fl, lv_fl,
                input ov_f, ov_w, uv_w, uv_f, oc_f, lv_below);
   modport cmp (input signed_fmt, meas_volt, meas_curr, ov_fl, ov_wl, uv_wl, uv_fl, oc_fl, lv_fl,
                output ov_f, ov_w, uv_w, uv_f, oc_f, lv_below);
endinterface : limit_if

// file: design/output_fault_status_logic.sv
// output voltage and current fault supervisor with status registers and clear command
// Summary of operation
// - clear command zeroes every status register in one cycle
// - clear releases the alert line in the same cycle as the status bits
// - clear never restarts a latched-off output; only restart request does
// - a fault still present after clear sets its bit again and notifies
// - clear is write-only with no data; reading it is refused
// - voltage limits hold two bytes in the selected number format
// - overvoltage fault sets byte, word and voltage-status bits, notifies fault
// - high voltage warning sets other, word and warning bits, notifies warning
// - low voltage warning masked until target reached and while disabled
// - low voltage warning sets other, word and warning bits, notifies warning
// - low voltage fault masked until target reached and while disabled
// - low voltage fault limit and low-volt overcurrent threshold reset to zero
// - low voltage fault sets other, word and fault bits, notifies fault
// - overcurrent limit holds a two-byte current; exceeding it is a fault
// - overcurrent fault sets byte, word and current-status bits, notifies fault
// - constant-current mode limits until voltage drops below low-volt threshold
// - low-volt overcurrent sets byte, word and its current-status bit, notifies
`timescale 1ns/1ps
module output_fault_status_logic
   import fault_pkg::*;
#(
   parameter fault_pkg::word_t OV_FAULT_RST = fault_pkg::LIMIT_TOP,
   parameter fault_pkg::word_t OV_WARN_RST  = fault_pkg::LIMIT_TOP,
   parameter fault_pkg::word_t UV_WARN_RST  = fault_pkg::LIMIT_ZERO,
   parameter fault_pkg::word_t OC_FAULT_RST = fault_pkg::LIMIT_TOP
) (
   input  wire logic             ref_clk,
   input  wire logic             rst,
   input  wire logic             cmd_valid,
   input  wire fault_pkg::byte_t cmd_code,
   input  wire logic             cmd_has_data,
   input  wire fault_pkg::word_t cmd_data,
   output logic                  cmd_err,
   input  wire logic             rd_en,
   input  wire fault_pkg::byte_t rd_cmd,
   output fault_pkg::word_t      rd_data,
   output logic                  rd_valid,
   output logic                  rd_err,
   input  wire logic             meas_valid,
   input  wire fault_pkg::word_t meas_volt,
   input  wire fault_pkg::word_t meas_curr,
   input  wire logic             out_enabled,
   input  wire logic             out_at_target,
   input  wire logic             restart_req,
   output logic                  latched_off,
   output logic                  cc_limit_active,
   output fault_pkg::byte_t      status_byte,
   output fault_pkg::word_t      status_word,
   output fault_pkg::byte_t      out_volt_status_reg,
   output fault_pkg::byte_t      out_curr_status_reg,
   output logic                  alert_n_o,
   output logic                  alert_n_oe,
   output logic                  fault_notify,
   output logic                  warn_notify
);
   import fault_pkg::*;

   typedef struct packed {
      word_t ov_fl;
      word_t ov_wl;
      word_t uv_wl;
      word_t uv_fl;
      word_t oc_fl;
      word_t lv_fl;
      byte_t ov_act;
      byte_t uv_act;
      byte_t oc_act;
      byte_t lv_act;
      byte_t vfmt;
      byte_t sbyte;
      byte_t shi;
      byte_t svolt;
      byte_t scurr;
      logic  reached;
      logic  cc;
      logic  latch;
      word_t rdata;
      logic  rvalid;
      logic  rerr;
      logic  werr;
   } main_state_t;

   localparam main_state_t ST_RST = '{ov_fl: OV_FAULT_RST, ov_wl: OV_WARN_RST,
                                      uv_wl: UV_WARN_RST, oc_fl: OC_FAULT_RST,
                                      uv_fl: LIMIT_ZERO, lv_fl: LIMIT_ZERO, default: '0};

   main_state_t st_r;
   main_state_t st_nxt;
   limit_if     lim ();

   logic  clr;
   logic  uv_open;
   logic  cc_mode;
   logic  set_ovf;
   logic  set_ovw;
   logic  set_uvw;
   logic  set_uvf;
   logic  set_ocf;
   logic  set_lvf;
   logic  fault_set;
   logic  warn_set;
   byte_t sb_set;
   byte_t shi_set;
   byte_t sv_set;
   byte_t sc_set;

   ////////////////////////////////////////////////////////////////////////////
   // comparator hookup
   assign lim.signed_fmt = (st_r.vfmt[FMT_HI:FMT_LO] == FMT_SIGNED);
   assign lim.meas_volt  = meas_volt;
   assign lim.meas_curr  = meas_curr;
   assign lim.ov_fl      = st_r.ov_fl;
   assign lim.ov_wl      = st_r.ov_wl;
   assign lim.uv_wl      = st_r.uv_wl;
   assign lim.uv_fl      = st_r.uv_fl;
   assign lim.oc_fl      = st_r.oc_fl;
   assign lim.lv_fl      = st_r.lv_fl;

   limit_compare u_cmp (
      .lim (lim)
   );

   ////////////////////////////////////////////////////////////////////////////
   // crossing detection, one decision per measurement
   assign clr      = cmd_valid && (cmd_code == CMD_CLEAR) && !cmd_has_data;
   assign uv_open  = st_r.reached && out_enabled;
   assign cc_mode  = (st_r.oc_act[ACT_HI:ACT_LO] == ACT_CC);
   assign set_ovf  = meas_valid && lim.ov_f;
   assign set_ovw  = meas_valid && lim.ov_w;
   assign set_uvw  = meas_valid && lim.uv_w && uv_open;
   assign set_uvf  = meas_valid && lim.uv_f && uv_open;
   assign set_ocf  = meas_valid && lim.oc_f;
   assign set_lvf  = set_ocf && cc_mode && lim.lv_below;
   assign fault_set = set_ovf | set_uvf | set_ocf | set_lvf;
   assign warn_set  = set_ovw | set_uvw;

   always_comb begin
      sb_set  = '0;
      shi_set = '0;
      sv_set  = '0;
      sc_set  = '0;
      sb_set[SB_VOLT_HIGH]  = set_ovf;
      sb_set[SB_OTHER]      = set_ovw | set_uvw | set_uvf;
      sb_set[SB_CURR_HIGH]  = set_ocf | set_lvf;
      shi_set[SW_VOLT]      = set_ovf | set_ovw | set_uvw | set_uvf;
      shi_set[SW_CURR]      = set_ocf | set_lvf;
      sv_set[VS_HIGH_FAULT] = set_ovf;
      sv_set[VS_HIGH_WARN]  = set_ovw;
      sv_set[VS_LOW_WARN]   = set_uvw;
      sv_set[VS_LOW_FAULT]  = set_uvf;
      sc_set[CS_HIGH_FAULT] = set_ocf;
      sc_set[CS_LOW_VOLT]   = set_lvf;
   end

   ////////////////////////////////////////////////////////////////////////////
   // next state
   always_comb begin
      st_nxt        = st_r;
      st_nxt.rvalid = 1'b0;
      st_nxt.rerr   = 1'b0;
      st_nxt.werr   = 1'b0;
      // a crossing in the clearing cycle survives the clear
      st_nxt.sbyte = (clr ? BYTE_ZERO : st_r.sbyte) | sb_set;
      st_nxt.shi   = (clr ? BYTE_ZERO : st_r.shi)   | shi_set;
      st_nxt.svolt = (clr ? BYTE_ZERO : st_r.svolt) | sv_set;
      st_nxt.scurr = (clr ? BYTE_ZERO : st_r.scurr) | sc_set;
      // armed only once the output has come up, dropped whenever disabled
      st_nxt.reached = out_enabled && (st_r.reached || out_at_target);
      if (meas_valid) begin
         st_nxt.cc = set_ocf && cc_mode && !lim.lv_below;
      end
      // latch is independent of clr on purpose
      st_nxt.latch = (st_r.latch && !restart_req) ||
                     (set_ovf && st_r.ov_act[ACT_HI:ACT_LO] == ACT_LATCH) ||
                     (set_uvf && st_r.uv_act[ACT_HI:ACT_LO] == ACT_LATCH) ||
                     (set_ocf && !cc_mode && st_r.oc_act[ACT_HI:ACT_LO] == ACT_LATCH) ||
                     (set_lvf && st_r.lv_act[ACT_HI:ACT_LO] == ACT_LATCH);
      if (cmd_valid && cmd_has_data) begin
         case (cmd_code)
            CMD_VOLT_FMT: st_nxt.vfmt   = cmd_data[7:0];
            CMD_OV_FLIM:  st_nxt.ov_fl  = cmd_data;
            CMD_OV_FACT:  st_nxt.ov_act = cmd_data[7:0];
            CMD_OV_WLIM:  st_nxt.ov_wl  = cmd_data;
            CMD_UV_WLIM:  st_nxt.uv_wl  = cmd_data;
            CMD_UV_FLIM:  st_nxt.uv_fl  = cmd_data;
            CMD_UV_FACT:  st_nxt.uv_act = cmd_data[7:0];
            CMD_OC_FLIM:  st_nxt.oc_fl  = cmd_data;
            CMD_OC_FACT:  st_nxt.oc_act = cmd_data[7:0];
            CMD_LV_FLIM:  st_nxt.lv_fl  = cmd_data;
            CMD_LV_FACT:  st_nxt.lv_act = cmd_data[7:0];
            default:      st_nxt.werr   = 1'b1;
         endcase
      end else if (cmd_valid && !clr) begin
         st_nxt.werr = 1'b1;
      end
      if (rd_en) begin
         st_nxt.rvalid = 1'b1;
         case (rd_cmd)
            CMD_VOLT_FMT: st_nxt.rdata = word_t'(st_r.vfmt);
            CMD_OV_FLIM:  st_nxt.rdata = st_r.ov_fl;
            CMD_OV_FACT:  st_nxt.rdata = word_t'(st_r.ov_act);
            CMD_OV_WLIM:  st_nxt.rdata = st_r.ov_wl;
            CMD_UV_WLIM:  st_nxt.rdata = st_r.uv_wl;
            CMD_UV_FLIM:  st_nxt.rdata = st_r.uv_fl;
            CMD_UV_FACT:  st_nxt.rdata = word_t'(st_r.uv_act);
            CMD_OC_FLIM:  st_nxt.rdata = st_r.oc_fl;
            CMD_OC_FACT:  st_nxt.rdata = word_t'(st_r.oc_act);
            CMD_LV_FLIM:  st_nxt.rdata = st_r.lv_fl;
            CMD_LV_FACT:  st_nxt.rdata = word_t'(st_r.lv_act);
            CMD_ST_BYTE:  st_nxt.rdata = word_t'(st_r.sbyte);
            CMD_ST_WORD:  st_nxt.rdata = {st_r.shi, st_r.sbyte};
            CMD_ST_VOLT:  st_nxt.rdata = word_t'(st_r.svolt);
            CMD_ST_CURR:  st_nxt.rdata = word_t'(st_r.scurr);
            default: begin
               // includes the clear code, which has nothing to read
               st_nxt.rdata  = LIMIT_ZERO;
               st_nxt.rvalid = 1'b0;
               st_nxt.rerr   = 1'b1;
            end
         endcase
      end
   end

   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         st_r <= ST_RST;
      end else begin
         st_r <= st_nxt;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // alert line and notifications
   alert_ctrl u_alert (
      .ref_clk      (ref_clk),
      .rst          (rst),
      .fault_set    (fault_set),
      .warn_set     (warn_set),
      .clear        (clr),
      .alert_n_o    (alert_n_o),
      .alert_n_oe   (alert_n_oe),
      .fault_notify (fault_notify),
      .warn_notify  (warn_notify)
   );

   assign status_byte         = st_r.sbyte;
   assign status_word         = {st_r.shi, st_r.sbyte};
   assign out_volt_status_reg = st_r.svolt;
   assign out_curr_status_reg = st_r.scurr;
   assign latched_off         = st_r.latch;
   assign cc_limit_active     = st_r.cc;
   assign rd_data             = st_r.rdata;
   assign rd_valid            = st_r.rvalid;
   assign rd_err              = st_r.rerr;
   assign cmd_err             = st_r.werr;

   ////////////////////////////////////////////////////////////////////////////
   // checks
   sequence s_clear_quiet;
      clr && !fault_set && !warn_set;
   endsequence

   sequence s_ov_fault;
      meas_valid && lim.ov_f;
   endsequence

   property p_clear_all;
      @(posedge ref_clk) disable iff (rst)
      s_clear_quiet |=> (status_word == '0) && (out_volt_status_reg == '0) && (out_curr_status_reg == '0);
   endproperty
   a_clear_all: assert property (p_clear_all) else $error("status not cleared");

   property p_alert_release;
      @(posedge ref_clk) disable iff (rst)
      (alert_n_oe and s_clear_quiet) |=> !alert_n_oe && (status_byte == '0);
   endproperty
   a_alert_release: assert property (p_alert_release) else $error("alert not released");

   property p_latch_kept;
      @(posedge ref_clk) disable iff (rst)
      (latched_off && clr && !restart_req) |=> latched_off;
   endproperty
   a_latch_kept: assert property (p_latch_kept) else $error("clear restarted output");

   property p_reassert;
      @(posedge ref_clk) disable iff (rst)
      (clr ##0 s_ov_fault) |=> out_volt_status_reg[VS_HIGH_FAULT] && alert_n_oe && fault_notify;
   endproperty
   a_reassert: assert property (p_reassert) else $error("persisting fault lost on clear");

   property p_no_read_clear;
      @(posedge ref_clk) disable iff (rst)
      (rd_en && rd_cmd == CMD_CLEAR) |=> rd_err && !rd_valid;
   endproperty
   a_no_read_clear: assert property (p_no_read_clear) else $error("clear code was readable");

   property p_ov_fault;
      @(posedge ref_clk) disable iff (rst)
      s_ov_fault |=> status_byte[SB_VOLT_HIGH] && status_word[8 + SW_VOLT] &&
                     out_volt_status_reg[VS_HIGH_FAULT] && fault_notify;
   endproperty
   a_ov_fault: assert property (p_ov_fault) else $error("overvoltage fault not reported");

   property p_ov_warn;
      @(posedge ref_clk) disable iff (rst)
      (meas_valid && lim.ov_w) |=> status_byte[SB_OTHER] && out_volt_status_reg[VS_HIGH_WARN] && warn_notify;
   endproperty
   a_ov_warn: assert property (p_ov_warn) else $error("high warning not reported");

   property p_uvw_mask;
      @(posedge ref_clk) disable iff (rst)
      $rose(out_volt_status_reg[VS_LOW_WARN]) |-> $past(uv_open);
   endproperty
   a_uvw_mask: assert property (p_uvw_mask) else $error("low warning not masked");

   property p_uv_warn;
      @(posedge ref_clk) disable iff (rst)
      (meas_valid && lim.uv_w && uv_open) |=> status_byte[SB_OTHER] && out_volt_status_reg[VS_LOW_WARN] &&
                                              warn_notify;
   endproperty
   a_uv_warn: assert property (p_uv_warn) else $error("low warning not reported");

   property p_uvf_mask;
      @(posedge ref_clk) disable iff (rst)
      $rose(out_volt_status_reg[VS_LOW_FAULT]) |-> $past(uv_open);
   endproperty
   a_uvf_mask: assert property (p_uvf_mask) else $error("low fault not masked");

   property p_zero_rst;
      @(posedge ref_clk) $fell(rst) |-> (st_r.uv_fl == LIMIT_ZERO) && (st_r.lv_fl == LIMIT_ZERO);
   endproperty
   a_zero_rst: assert property (p_zero_rst) else $error("limit not zero after reset");

   property p_uv_fault;
      @(posedge ref_clk) disable iff (rst)
      (meas_valid && lim.uv_f && uv_open) |=> status_byte[SB_OTHER] && out_volt_status_reg[VS_LOW_FAULT] &&
                                              fault_notify;
   endproperty
   a_uv_fault: assert property (p_uv_fault) else $error("low fault not reported");

   property p_oc_fault;
      @(posedge ref_clk) disable iff (rst)
      (meas_valid && meas_curr > st_r.oc_fl) |=> status_byte[SB_CURR_HIGH] && status_word[8 + SW_CURR] &&
                                                out_curr_status_reg[CS_HIGH_FAULT] && fault_notify;
   endproperty
   a_oc_fault: assert property (p_oc_fault) else $error("overcurrent not reported");

   property p_cc_limit;
      @(posedge ref_clk) disable iff (rst)
      (set_ocf && cc_mode && !lim.lv_below) |=> cc_limit_active && !fault_notify == 1'b0;
   endproperty
   a_cc_limit: assert property (p_cc_limit) else $error("constant current state wrong");

   property p_lv_fault;
      @(posedge ref_clk) disable iff (rst)
      set_lvf |=> status_byte[SB_CURR_HIGH] && out_curr_status_reg[CS_LOW_VOLT] && fault_notify && !cc_limit_active;
   endproperty
   a_lv_fault: assert property (p_lv_fault) else $error("low-volt overcurrent not reported");

   property p_sticky;
      @(posedge ref_clk) disable iff (rst)
      (out_volt_status_reg[VS_HIGH_FAULT] && !clr) |=> out_volt_status_reg[VS_HIGH_FAULT] [*1];
   endproperty
   a_sticky: assert property (p_sticky) else $error("status bit did not stick");
endmodule : output_fault_status_logic

// file: tb/host_model.sv
// management host model issuing commands and reads
`timescale 1ns/1ps
module host_model
   import fault_pkg::*;
(
   input  wire logic             ref_clk,
   output logic                  cmd_valid,
   output fault_pkg::byte_t      cmd_code,
   output logic                  cmd_has_data,
   output fault_pkg::word_t      cmd_data,
   output logic                  rd_en,
   output fault_pkg::byte_t      rd_cmd,
   input  wire fault_pkg::word_t rd_data
);
   import fault_pkg::*;
   initial begin
      cmd_valid = 1'b0;
      cmd_code = 8'h00;
      cmd_has_data = 1'b0;
      cmd_data = 16'h0000;
      rd_en = 1'b0;
      rd_cmd = 8'h00;
   end
   // data lines flip once the strobe drops, so stale data never looks valid
   task automatic send(input byte_t c, input logic d, input word_t v);
      @(negedge ref_clk);
      cmd_valid = 1'b1;
      cmd_code = c;
      cmd_has_data = d;
      cmd_data = v;
      @(negedge ref_clk);
      cmd_valid = 1'b0;
      cmd_data = ~v;
   endtask : send
   task automatic read(input byte_t c, output word_t v);
      @(negedge ref_clk);
      rd_en = 1'b1;
      rd_cmd = c;
      @(negedge ref_clk);
      rd_en = 1'b0;
      rd_cmd = ~c;
      v = rd_data;
   endtask : read
endmodule : host_model

// file: tb/output_fault_status_logic_bench.sv
// self-checking bench of the output fault supervisor
`timescale 1ns/1ps
module output_fault_status_logic_bench;
   import fault_pkg::*;
   logic ref_clk = 1'b0, rst = 1'b1, meas_valid = 1'b0, out_enabled = 1'b0, out_at_target = 1'b0;
   logic restart_req = 1'b0, cmd_valid, cmd_has_data, cmd_err, rd_en, rd_valid, rd_err, latched_off;
   logic cc_limit_active, alert_n_o, alert_n_oe, fault_notify, warn_notify;
   word_t meas_volt = 16'h0000, meas_curr = 16'h0000, cmd_data, rd_data, status_word, rv;
   byte_t cmd_code, rd_cmd, status_byte, out_volt_status_reg, out_curr_status_reg;
   int n_errors = 0, cmp_count = 0;
   always #5 ref_clk = ~ref_clk;
   output_fault_status_logic dut (.ref_clk, .rst, .cmd_valid, .cmd_code, .cmd_has_data, .cmd_data,
      .cmd_err, .rd_en, .rd_cmd, .rd_data, .rd_valid, .rd_err, .meas_valid, .meas_volt, .meas_curr,
      .out_enabled, .out_at_target, .restart_req, .latched_off, .cc_limit_active, .status_byte,
      .status_word, .out_volt_status_reg, .out_curr_status_reg, .alert_n_o, .alert_n_oe,
      .fault_notify, .warn_notify);
   host_model host (.ref_clk, .cmd_valid, .cmd_code, .cmd_has_data, .cmd_data, .rd_en, .rd_cmd,
      .rd_data);
   ////////////////////////////////////////////////////////////////////////////
   task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
      cmp_count++;
      if (g !== e) begin
         n_errors++;
         $display("MISMATCH %s exp %h got %h", n, e, g);
      end
   endtask : chk
   task automatic meas(input word_t v, input word_t c);
      @(negedge ref_clk);
      meas_valid = 1'b1;
      meas_volt = v;
      meas_curr = c;
      @(negedge ref_clk);
      meas_valid = 1'b0;
   endtask : meas
   task automatic report_and_stop;
      $display("checks %0d errors %0d", cmp_count, n_errors);
      if (n_errors == 0 && cmp_count > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask : report_and_stop
   ////////////////////////////////////////////////////////////////////////////
   initial begin
      #20us;
      n_errors++;
      report_and_stop();
   end
   initial begin
      repeat (3) @(negedge ref_clk);
      rst = 1'b0;
      host.read(CMD_UV_FLIM, rv);
      chk("uv_flim", 16'h0000, rv);
      host.read(CMD_LV_FLIM, rv);
      chk("lv_thr", 16'h0000, rv);
      host.read(CMD_CLEAR, rv);
      chk("clr_rd", 16'h0001, {15'h0, rd_err});
      host.send(CMD_OV_FLIM, 1'b1, 16'h8000);
      host.send(CMD_OV_FACT, 1'b1, 16'h0080);
      meas(16'h9000, 16'h0000);
      chk("ov_st", 16'h8020, status_word);
      chk("ov_fl", 16'h8007, {out_volt_status_reg, 5'h0, fault_notify, alert_n_oe, latched_off});
      host.send(CMD_CLEAR, 1'b0, 16'h0000);
      chk("clr_st", 16'h0000, status_word | {out_volt_status_reg, out_curr_status_reg});
      chk("clr_fl", 16'h0001, {14'h0, alert_n_oe, latched_off});
      // clear and a still-present crossing share one edge
      fork
         host.send(CMD_CLEAR, 1'b0, 16'h0000);
         meas(16'h9000, 16'h0000);
      join
      chk("again", 16'h8021, {status_word[15:1], alert_n_oe});
      host.send(CMD_CLEAR, 1'b0, 16'h0000);
      restart_req = 1'b1;
      @(negedge ref_clk);
      restart_req = 1'b0;
      chk("restart", 16'h0000, {15'h0, latched_off});
      host.send(CMD_UV_WLIM, 1'b1, 16'h1000);
      host.send(CMD_UV_FLIM, 1'b1, 16'h0c00);
      meas(16'h0800, 16'h0000);
      chk("uv_mask", 16'h0000, status_word | {8'h0, out_volt_status_reg});
      out_enabled = 1'b1;
      out_at_target = 1'b1;
      meas(16'h0800, 16'h0000);
      chk("uv_st", 16'h8001, status_word);
      chk("uv_fl", 16'h3003, {out_volt_status_reg, 6'h0, fault_notify, warn_notify});
      out_enabled = 1'b0;
      host.send(CMD_CLEAR, 1'b0, 16'h0000);
      host.send(CMD_OC_FLIM, 1'b1, 16'h0100);
      host.send(CMD_LV_FLIM, 1'b1, 16'h0400);
      meas(16'h0800, 16'h0200);
      chk("oc_st", 16'h4010, status_word);
      chk("oc_cs", 16'h8003, {out_curr_status_reg, 6'h0, cc_limit_active, fault_notify});
      meas(16'h0200, 16'h0200);
      chk("lv_cs", 16'hc000, {out_curr_status_reg, 7'h0, cc_limit_active});
      host.read(CMD_ST_CURR, rv);
      chk("cs_rd", 16'h00c0, rv);
      chk("rd_ok", 16'h0001, {15'h0, rd_valid});
      // clear with a data word is refused and leaves the status alone
      host.send(CMD_CLEAR, 1'b1, 16'h0000);
      chk("clr_err", 16'h0001, {15'h0, cmd_err});
      chk("clr_kept", 16'h4010, status_word);
      chk("alert_pin", 16'h0001, {14'h0, alert_n_o, alert_n_oe});
      // signed format: 8000 is negative, so only the later 0200 crosses the warning
      host.send(CMD_OV_FLIM, 1'b1, 16'h7fff);
      host.send(CMD_OV_WLIM, 1'b1, 16'h0100);
      host.send(CMD_VOLT_FMT, 1'b1, 16'h0060);
      host.send(CMD_CLEAR, 1'b0, 16'h0000);
      meas(16'h8000, 16'h0000);
      chk("sgn_low", 16'h0000, status_word);
      meas(16'h0200, 16'h0000);
      chk("ovw_st", 16'h8001, status_word);
      chk("ovw_vs", 16'h4001, {out_volt_status_reg, 7'h0, warn_notify});
      report_and_stop();
   end
endmodule : output_fault_status_logic_bench
